// File: rtl/dws_consts.svh
// Purpose: Shared constants for the converter two-wire link.
// Assumes: Included by both ends and by the wire-level property checker.
// Notes: Timing values are in ns; mclk runs at 125 MHz (8 ns period).
`ifndef DWS_CONSTS_SVH
`define DWS_CONSTS_SVH

`define DWS_BCAST_ADDR 7'h48
`define DWS_MCODE_TOP 5'h01
`define DWS_DATA_RESET 16'h0000
`define DWS_PD_HI_BIT 15
`define DWS_PD_LO_BIT 14
`define DWS_CODE_MSB 11
`define DWS_BIT_LAST 4'h7
`define DWS_BIT_ACK 4'h8
`define DWS_CLK_PERIOD_NS 8
`define DWS_SF_HALF_NS 1250
`define DWS_HS_HALF_NS 150

`endif

// File: rtl/dws_pkg.sv
// Purpose: Types shared by both ends of the converter link.
// Assumes: Constants come from dws_consts.svh.
// Notes: Holds enumerations only.
package dws_pkg;
    typedef enum logic [2:0] {
        DWS_S_IDLE = 3'b000,
        DWS_S_ADDR = 3'b001,
        DWS_S_WR = 3'b010,
        DWS_S_RD = 3'b011,
        DWS_S_IGN = 3'b100
    } dws_dev_state_t;
    typedef enum logic [3:0] {
        DWS_M_IDLE = 4'h0,
        DWS_M_START = 4'h1,
        DWS_M_LOW = 4'h2,
        DWS_M_HIGH = 4'h3,
        DWS_M_STOP_A = 4'h4,
        DWS_M_STOP_B = 4'h5,
        DWS_M_RS_A = 4'h6,
        DWS_M_RS_B = 4'h7,
        DWS_M_DONE = 4'h8
    } dws_host_state_t;
endpackage

// File: rtl/dws_if.sv
// Purpose: Two-wire bus between the converter end and the master end.
// Assumes: Pull-up resolution is done by the bench from the enables.
// Notes: Enables are low while a party pulls its line low.
`timescale 1ns/1ps
interface dws_if;
    logic scl_in;
    logic sda_in;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic host_scl_out;
    logic host_scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    modport device (input scl_in, input sda_in, output dev_sda_out, output dev_sda_oe_n);
    modport host (input scl_in, input sda_in, output host_scl_out, output host_scl_oe_n,
        output host_sda_out, output host_sda_oe_n);
endinterface

// File: rtl/dws_device.sv
// Purpose: Slave end of the converter two-wire link with its data register.
// Assumes: Bus lines are asynchronous and pass two flip-flops first.
// Notes: Speed class changes no sampling; it is reported as a status output.
`timescale 1ns/1ps
`include "dws_consts.svh"

// Contract
// - Code is unsigned 0..4095, output code over 4096.
// - Serves standard-fast and high-speed classes alike.
// - Send zero by pulling low, one by release.
// - Acknowledge own address, release on mismatch.
// - Acknowledge every fully received write byte.
// - Master acknowledges reads, nacks last, then stops.
// - Start is data falling while clock high.
// - Repeated start keeps speed, then address follows.
// - Stop is data rising while clock high.
// - Address plus direction, then device answers.
// - Write sends high byte then low byte.
// - Low byte acknowledged loads register, updates output.
// - Further byte pairs accepted until stop or restart.
// - Read returns high byte then low byte.
// - Master code answered with not-acknowledge.
// - Master raises speed and restarts after code.
// - High speed persists across restarts until stop.
// - Any stop returns to standard-fast class.
// - Also answers broadcast address 1001000.
// - Strap address locks on first direct match.
// - Register and output zero after reset.
// - Power-down bits stop output, word stays readable.
module dws_device
    import dws_pkg::*;
#(
    parameter logic [6:0] STRAP_BASE = 7'h0C
) (
    input wire logic mclk,
    input wire logic resetn,
    dws_if.device bus,
    input wire logic [1:0] address_strap_a,
    input wire logic [1:0] address_strap_b,
    output logic [11:0] conv_code,
    output logic power_down_select_hi,
    output logic power_down_select_lo,
    output logic powered_down,
    output logic hs_active,
    output logic addr_locked
);
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    dws_dev_state_t state_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic low_half_r, mcode_r, drive_low_r, pend_low_r;
    logic [15:0] data_r;
    logic [7:0] hi_hold_r;
    logic [6:0] own_addr_r;

    // ************************************************************
    // Input synchronisers and condition detection.
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
        end else begin
            scl_m_r <= bus.scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= bus.sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end
    assign scl_rise = scl_s_r && !scl_d_r;
    assign scl_fall = !scl_s_r && scl_d_r;
    assign start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    assign stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

    function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] own);
        addr_hit = (a == own) || (a == `DWS_BCAST_ADDR);
    endfunction

    // ************************************************************
    // Protocol state machine.
    // ************************************************************
    logic [7:0] rx_byte;
    assign rx_byte = {shift_r[6:0], sda_s_r};

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= DWS_S_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            low_half_r <= 1'b0;
            pend_low_r <= 1'b0;
            hi_hold_r <= 8'h00;
        end else if (start_ev) begin
            state_r <= DWS_S_ADDR;
            bit_r <= 4'h0;
            low_half_r <= 1'b0;
            pend_low_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= DWS_S_IDLE;
        end else if (scl_rise && state_r != DWS_S_IDLE && state_r != DWS_S_IGN) begin
            if (bit_r <= `DWS_BIT_LAST) begin
                shift_r <= rx_byte;
                bit_r <= bit_r + 4'h1;
            end else begin
                bit_r <= 4'h0;
                case (state_r)
                    DWS_S_ADDR: begin
                        if (!mcode_r && addr_hit(shift_r[7:1], own_addr_r)) begin
                            state_r <= shift_r[0] ? DWS_S_RD : DWS_S_WR;
                        end else begin
                            state_r <= DWS_S_IGN;
                        end
                    end
                    DWS_S_WR: begin
                        if (!low_half_r) begin
                            hi_hold_r <= shift_r;
                        end
                        pend_low_r <= low_half_r;
                        low_half_r <= !low_half_r;
                    end
                    DWS_S_RD: begin
                        if (sda_s_r || low_half_r) begin
                            state_r <= DWS_S_IGN;
                        end
                        low_half_r <= 1'b1;
                    end
                    default: state_r <= DWS_S_IGN;
                endcase
            end
        end else if (pend_low_r) begin
            pend_low_r <= 1'b0;
        end
    end

    // Master code is recognised in the address slot and never acknowledged.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mcode_r <= 1'b0;
        end else if (state_r == DWS_S_ADDR && bit_r == `DWS_BIT_LAST && scl_rise) begin
            mcode_r <= (rx_byte[7:3] == `DWS_MCODE_TOP);
        end
    end

    // ************************************************************
    // Speed class and address lock.
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hs_active <= 1'b0;
        end else if (stop_ev) begin
            hs_active <= 1'b0;
        end else if (start_ev && mcode_r && state_r == DWS_S_IGN) begin
            hs_active <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            addr_locked <= 1'b0;
            own_addr_r <= STRAP_BASE;
        end else if (!addr_locked) begin
            own_addr_r <= STRAP_BASE ^ {2'b00, address_strap_b, 1'b0, address_strap_a};
            if (state_r == DWS_S_ADDR && bit_r == `DWS_BIT_ACK && scl_rise
                && shift_r[7:1] == own_addr_r && !mcode_r) begin
                addr_locked <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Data register and converter outputs.
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            data_r <= `DWS_DATA_RESET;
        end else if (pend_low_r) begin
            data_r <= {hi_hold_r, shift_r};
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            conv_code <= 12'h000;
            power_down_select_hi <= 1'b0;
            power_down_select_lo <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            power_down_select_hi <= data_r[`DWS_PD_HI_BIT];
            power_down_select_lo <= data_r[`DWS_PD_LO_BIT];
            powered_down <= data_r[`DWS_PD_HI_BIT] | data_r[`DWS_PD_LO_BIT];
            conv_code <= (data_r[`DWS_PD_HI_BIT] | data_r[`DWS_PD_LO_BIT])
                ? 12'h000 : data_r[`DWS_CODE_MSB:0];
        end
    end

    // ************************************************************
    // Data line driver, updated after a clock fall and released on start or stop.
    // ************************************************************
    logic [15:0] rd_word;
    assign rd_word = data_r;
    always_ff @(posedge mclk) begin
        if (!resetn || start_ev || stop_ev) begin
            drive_low_r <= 1'b0;
        end else if (scl_fall) begin
            drive_low_r <= 1'b0;
            if (bit_r == `DWS_BIT_ACK) begin
                case (state_r)
                    DWS_S_ADDR: drive_low_r <= !mcode_r && addr_hit(shift_r[7:1], own_addr_r);
                    DWS_S_WR: drive_low_r <= 1'b1;
                    default: drive_low_r <= 1'b0;
                endcase
            end else if (state_r == DWS_S_RD) begin
                drive_low_r <= !rd_word[{!low_half_r, 3'h7 - bit_r[2:0]}];
            end
        end
    end
    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_sda_oe_n = !drive_low_r;
endmodule

// File: rtl/dws_host.sv
// Purpose: Master end that writes or reads the converter word.
// Assumes: One request at a time; the bus has a single master.
// Notes: Bit rate comes from an enable divider on mclk.
`timescale 1ns/1ps
`include "dws_consts.svh"
module dws_host
    import dws_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    dws_if.host bus,
    input wire logic req,
    input wire logic req_read,
    input wire logic req_hs,
    input wire logic [6:0] req_addr,
    input wire logic [15:0] req_data,
    output logic busy,
    output logic done,
    output logic nacked,
    output logic [15:0] rd_data
);
    localparam int SF_HALF = (`DWS_SF_HALF_NS + `DWS_CLK_PERIOD_NS - 1) / `DWS_CLK_PERIOD_NS;
    localparam int HS_HALF = (`DWS_HS_HALF_NS + `DWS_CLK_PERIOD_NS - 1) / `DWS_CLK_PERIOD_NS;
    dws_host_state_t st_r;
    logic [7:0] div_r;
    logic tick, hs_r, scl_low_r, sda_low_r, mcode_ph_r, rd_r;
    logic [1:0] byte_r;
    logic [3:0] bit_r;
    logic [7:0] tx_r;
    logic sda_m_r, sda_s_r;

    // ************************************************************
    // Half-bit enable divider and data line synchroniser.
    // ************************************************************
    assign tick = (div_r == 8'h00);
    always_ff @(posedge mclk) begin
        if (!resetn || tick) begin
            div_r <= hs_r ? 8'(HS_HALF - 1) : 8'(SF_HALF - 1);
        end else begin
            div_r <= div_r - 8'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {sda_m_r, sda_s_r} <= 2'b11;
        end else begin
            sda_m_r <= bus.sda_in;
            sda_s_r <= sda_m_r;
        end
    end

    function automatic logic [7:0] pick_byte(input logic [1:0] n, input logic mc,
        input logic rd, input logic [6:0] a, input logic [15:0] d);
        if (mc) pick_byte = {`DWS_MCODE_TOP, 3'h0};
        else if (n == 2'd0) pick_byte = {a, rd};
        else if (n == 2'd1) pick_byte = d[15:8];
        else pick_byte = d[7:0];
    endfunction

    // ************************************************************
    // Transfer sequencer.
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r <= DWS_M_IDLE;
            {scl_low_r, sda_low_r, hs_r, mcode_ph_r, rd_r} <= 5'h00;
            {busy, done, nacked} <= 3'h0;
            byte_r <= 2'd0;
            bit_r <= 4'h0;
            tx_r <= 8'h00;
            rd_data <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (st_r == DWS_M_IDLE && req) begin
                st_r <= DWS_M_START;
                busy <= 1'b1;
                nacked <= 1'b0;
                rd_r <= req_read;
                mcode_ph_r <= req_hs;
                byte_r <= 2'd0;
            end else if (tick) begin
                case (st_r)
                    DWS_M_START: begin
                        sda_low_r <= 1'b1;
                        tx_r <= pick_byte(2'd0, mcode_ph_r, rd_r, req_addr, req_data);
                        bit_r <= 4'h0;
                        st_r <= DWS_M_LOW;
                    end
                    DWS_M_LOW: begin
                        scl_low_r <= 1'b1;
                        st_r <= DWS_M_HIGH;
                        if (bit_r == `DWS_BIT_ACK)
                            sda_low_r <= rd_r && byte_r == 2'd1 && !mcode_ph_r;
                        else if (rd_r && byte_r != 2'd0 && !mcode_ph_r)
                            sda_low_r <= 1'b0;
                        else
                            sda_low_r <= !tx_r[7];
                    end
                    DWS_M_HIGH: begin
                        scl_low_r <= 1'b0;
                        if (bit_r == `DWS_BIT_ACK) begin
                            bit_r <= 4'h0;
                            if (mcode_ph_r) begin
                                mcode_ph_r <= 1'b0;
                                hs_r <= 1'b1;
                                st_r <= DWS_M_RS_A;
                            end else if (!rd_r && sda_s_r) begin
                                nacked <= 1'b1;
                                st_r <= DWS_M_STOP_A;
                            end else if (byte_r == 2'd2) begin
                                st_r <= DWS_M_STOP_A;
                            end else if (rd_r && byte_r == 2'd0 && sda_s_r) begin
                                nacked <= 1'b1;
                                st_r <= DWS_M_STOP_A;
                            end else begin
                                byte_r <= byte_r + 2'd1;
                                tx_r <= pick_byte(byte_r + 2'd1, 1'b0, rd_r, req_addr, req_data);
                                st_r <= DWS_M_LOW;
                            end
                        end else begin
                            if (rd_r && byte_r != 2'd0)
                                rd_data <= {rd_data[14:0], sda_s_r};
                            tx_r <= {tx_r[6:0], 1'b0};
                            bit_r <= bit_r + 4'h1;
                            st_r <= DWS_M_LOW;
                        end
                    end
                    DWS_M_RS_A: begin
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b0;
                        st_r <= DWS_M_RS_B;
                    end
                    DWS_M_RS_B: begin
                        scl_low_r <= 1'b0;
                        st_r <= DWS_M_START;
                    end
                    DWS_M_STOP_A: begin
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        st_r <= DWS_M_STOP_B;
                    end
                    DWS_M_STOP_B: begin
                        scl_low_r <= 1'b0;
                        st_r <= DWS_M_DONE;
                    end
                    DWS_M_DONE: begin
                        sda_low_r <= 1'b0;
                        hs_r <= 1'b0;
                        busy <= 1'b0;
                        done <= 1'b1;
                        st_r <= DWS_M_IDLE;
                    end
                    default: st_r <= DWS_M_IDLE;
                endcase
            end
        end
    end
    assign bus.host_scl_out = 1'b0;
    assign bus.host_scl_oe_n = !scl_low_r;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe_n = !sda_low_r;
endmodule

// File: tb/dws_properties.sv
// Purpose: Wire-level checks of the two-wire link between both ends.
// Assumes: Inputs are the resolved and driven interface signals.
// Notes: Bit and byte counters are rebuilt from the wire.
`timescale 1ns/1ps
`include "dws_consts.svh"
module dws_properties
    import dws_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n,
    input wire logic host_scl_out,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_out,
    input wire logic host_sda_oe_n
);
    // ***********************************
    // Frame tracking.
    // ***********************************
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt_r;
    logic [3:0] byte_r;
    logic [7:0] shift_r;
    logic acked_r;
    logic dir_r;
    logic rise;
    logic start_c;
    logic stop_c;
    logic slot;
    assign rise = scl_in & ~scl_q;
    assign start_c = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_c = scl_in & scl_q & ~sda_q & sda_in;
    assign slot = rise && bit_cnt_r == 4'h8;
    always_ff @(posedge mclk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
    end
    always_ff @(posedge mclk) begin
        if (!resetn || start_c || stop_c) begin
            bit_cnt_r <= 4'h0;
            byte_r <= 4'h0;
        end else if (slot) begin
            bit_cnt_r <= 4'h0;
            byte_r <= byte_r + 4'h1;
        end else if (rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (rise && bit_cnt_r < 4'h8) begin
            shift_r <= {shift_r[6:0], sda_in};
        end
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            acked_r <= 1'h0;
            dir_r <= 1'h0;
        end else if (slot && byte_r == 4'h0) begin
            acked_r <= ~sda_in;
            dir_r <= shift_r[0];
        end
    end
    // ***********************************
    // Assertions.
    // ***********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    dev_low_only_a: assert property (dev_sda_out == 1'h0)
        else $error("device drove data high");
    host_low_only_a: assert property (!host_sda_out && !host_scl_out)
        else $error("master drove a line high");
    dev_pull_timing_a: assert property ($fell(dev_sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
        else $error("device pulled data outside clock low");
    dev_release_low_a: assert property ($rose(dev_sda_oe_n) |-> !scl_in)
        else $error("device released data while clock high");
    frame_align_a: assert property ((start_c || stop_c) |-> bit_cnt_r <= 4'h1)
        else $error("start or stop inside a byte");
    start_clock_a: assert property (start_c |-> ##[1:400] !scl_in)
        else $error("no clock after start");
    stop_idle_a: assert property (stop_c |=> (scl_in && sda_in) [*8])
        else $error("bus not idle after stop");
    addr_ack_slot_a: assert property ($fell(dev_sda_oe_n) && byte_r == 4'h0 |-> bit_cnt_r == 4'h8)
        else $error("device pulled data inside the address byte");
    mcode_nack_a: assert property (slot && byte_r == 4'h0 && shift_r[7:3] == `DWS_MCODE_TOP |-> sda_in)
        else $error("master code acknowledged");
    bcast_ack_a: assert property (slot && byte_r == 4'h0 && shift_r[7:1] == `DWS_BCAST_ADDR |-> !sda_in)
        else $error("broadcast address not acknowledged");
    wr_byte_ack_a: assert property (slot && byte_r != 4'h0 && acked_r && !dir_r |-> !sda_in)
        else $error("write byte not acknowledged");
    rd_master_ack_a: assert property (slot && byte_r != 4'h0 && acked_r && dir_r |-> sda_in == (byte_r == 4'h2))
        else $error("master read acknowledge wrong");
    cover property (slot && byte_r == 4'h0 && shift_r[7:3] == `DWS_MCODE_TOP);
    cover property (slot && byte_r == 4'h2 && acked_r && dir_r);
    cover property (slot && byte_r == 4'h0 && sda_in);
endmodule

// File: tb/dac_i2c_slave_write_read_tb_top.sv
// Purpose: Joins both link ends and checks writes, reads and speed classes.
// Assumes: Bus lines resolve through pull-ups from the enables.
// Notes: Expected results queue up and are compared on done.
`timescale 1ns/1ps
module dac_i2c_slave_write_read_tb_top
    import dws_pkg::*;
;
    // ***********************************
    // Bench signals.
    // ***********************************
    localparam logic [6:0] STRAP = 7'h0C;
    typedef struct packed {logic rd; logic nack; logic [15:0] word;} dws_exp_t;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic req, req_read, req_hs, pd_hi, pd_lo, powered_down, hs_active, addr_locked;
    logic busy, done, nacked, hs_seen;
    logic [6:0] req_addr, lock_addr;
    logic [15:0] req_data, rd_data, w;
    logic [15:0] reg_exp = 16'h0000;
    logic [1:0] strap_a, strap_b;
    logic [11:0] conv_code;
    logic [31:0] rng = 32'hECBA2C92;
    int failures = 0;
    int n_checks = 0;
    dws_exp_t exp_q[$];
    dws_exp_t mon_e;
    dws_if bus();
    always #4 mclk = ~mclk;
    assign bus.scl_in = bus.host_scl_oe_n;
    assign bus.sda_in = bus.host_sda_oe_n & bus.dev_sda_oe_n;
    dws_device #(.STRAP_BASE(STRAP)) i_dws_device (.mclk(mclk), .resetn(resetn), .bus(bus),
        .address_strap_a(strap_a), .address_strap_b(strap_b), .conv_code(conv_code),
        .power_down_select_hi(pd_hi), .power_down_select_lo(pd_lo),
        .powered_down(powered_down), .hs_active(hs_active), .addr_locked(addr_locked));
    dws_host i_dws_host (.mclk(mclk), .resetn(resetn), .bus(bus), .req(req),
        .req_read(req_read), .req_hs(req_hs), .req_addr(req_addr), .req_data(req_data),
        .busy(busy), .done(done), .nacked(nacked), .rd_data(rd_data));
    dws_properties i_dws_properties (.mclk(mclk), .resetn(resetn), .scl_in(bus.scl_in),
        .sda_in(bus.sda_in), .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n),
        .host_scl_out(bus.host_scl_out), .host_scl_oe_n(bus.host_scl_oe_n),
        .host_sda_out(bus.host_sda_out), .host_sda_oe_n(bus.host_sda_oe_n));
    // ***********************************
    // Helpers and compares.
    // ***********************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [6:0] own(input logic [1:0] a, input logic [1:0] b);
        return STRAP ^ {2'h0, b, 1'h0, a};
    endfunction
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_op(input logic rd, input logic hs, input logic [6:0] a,
        input logic [15:0] d, input logic nk);
        int n;
        if (!rd && !nk) begin
            reg_exp = d;
        end
        exp_q.push_back('{rd, nk, reg_exp});
        @(negedge mclk);
        {req_read, req_hs, req_addr, req_data} = {rd, hs, a, d};
        req = 1'h1;
        @(negedge mclk);
        req = 1'h0;
        n = 0;
        while (busy !== 1'h0 && n < 30000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 30000) begin
            failures++;
            wrap_up();
        end
        repeat (4) @(negedge mclk);
        cmp1(hs_seen, hs);
        cmp1(hs_active, 1'h0);
    endtask
    // ***********************************
    // Monitor, watchdog and main sequence.
    // ***********************************
    always @(posedge mclk) begin
        if (req === 1'h1) begin
            hs_seen = 1'h0;
        end else if (hs_active === 1'h1) begin
            hs_seen = 1'h1;
        end
        if (done === 1'h1) begin
            cmp1(exp_q.size() != 0, 1'h1);
            if (exp_q.size() != 0) begin
                mon_e = exp_q.pop_front();
                cmp1(nacked, mon_e.nack);
                if (mon_e.rd) begin
                    cmp16(rd_data, mon_e.word);
                end
                cmp16({4'h0, conv_code}, (|mon_e.word[15:14]) ? 16'h0 : {4'h0, mon_e.word[11:0]});
                cmp16({13'h0, pd_hi, pd_lo, powered_down}, {13'h0, mon_e.word[15:14], |mon_e.word[15:14]});
            end
        end
    end
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    initial begin
        {req, req_read, req_hs, req_addr, req_data} = '0;
        rng = xs(rng);
        strap_a = rng[1:0];
        strap_b = {2{rng[2]}};
        repeat (12) @(negedge mclk);
        resetn = 1'h1;
        @(negedge mclk);
        cmp16({4'h0, conv_code}, 16'h0000);
        cmp1(addr_locked, 1'h0);
        rng = xs(rng);
        do_op(1'h0, 1'h0, `DWS_BCAST_ADDR, rng[15:0] & 16'h3FFF, 1'h0);
        cmp1(addr_locked, 1'h0);
        rng = xs(rng);
        strap_a = rng[1:0];
        strap_b = {2{rng[2]}};
        lock_addr = own(strap_a, strap_b);
        do_op(1'h0, 1'h1, lock_addr, 16'hC000 | rng[27:16], 1'h0);
        cmp1(addr_locked, 1'h1);
        strap_a = ~strap_a;
        strap_b = ~strap_b;
        do_op(1'h1, 1'h0, lock_addr, 16'h0000, 1'h0);
        do_op(1'h0, 1'h1, own(strap_a, strap_b), 16'h0ABC, 1'h1);
        do_op(1'h0, 1'h1, 7'h20, 16'h0123, 1'h1);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            w = (i == 0) ? 16'h0FFF : (i == 1) ? 16'h0000
                : {(i == 2) ? 2'h1 : 2'h2, rng[13:0]};
            do_op(1'h0, 1'h1, lock_addr, w, 1'h0);
            do_op(1'h1, 1'h1, lock_addr, 16'h0000, 1'h0);
        end
        cmp1(exp_q.size() == 0, 1'h1);
        wrap_up();
    end
endmodule
